// ==== frpa_map.svh ====
/*
 * Constants of the flash host controller: timing figures in ns, a macro
 * for their cycle counts, and address field positions.
 * Assumes a 100 MHz clock; included by bare name.
 */
`ifndef FRPA_MAP_SVH
`define FRPA_MAP_SVH

// Clock period in ns
`define FRPA_CLK_NS 10
// Cycles for a least time: rounded up, never below one
`define FRPA_CYC_MIN(ns) ((((ns) + `FRPA_CLK_NS - 1) / `FRPA_CLK_NS) < 1 ? 1 : (((ns) + `FRPA_CLK_NS - 1) / `FRPA_CLK_NS))

// Timing figures in ns
`define FRPA_CLEAR_PULSE_MIN_NS 500
`define FRPA_READY_IDLE_NS 500
`define FRPA_READY_ALG_NS 20000
`define FRPA_READ_AFTER_RELEASE_NS 50
`define FRPA_WE_PULSE_NS 40
`define FRPA_ACCESS_NS 90
`define FRPA_BUSY_SETTLE_NS 100

// Address field positions
`define FRPA_SECTOR_LSB 16
`define FRPA_GROUP_LSB 17
`define FRPA_A9_BIT 9
`define FRPA_A6_BIT 6

`endif

// ==== frpa_pkg.sv ====
/*
 * Types of the flash host controller.
 * Assumes nothing of its surroundings.
 */
package frpa_pkg;

    // Operations that the user may request
    typedef enum logic [2:0] {
        FRPA_OP_READ,
        FRPA_OP_PROGRAM,
        FRPA_OP_ERASE_SECTOR,
        FRPA_OP_ID_CMD,
        FRPA_OP_ID_HV,
        FRPA_OP_HW_RESET
    } frpa_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        FRPA_S_IDLE,
        FRPA_S_ISSUE,
        FRPA_S_CYCLE,
        FRPA_S_SETTLE,
        FRPA_S_BUSY,
        FRPA_S_RST_LOW,
        FRPA_S_RST_RECOVER,
        FRPA_S_RST_HOLDOFF
    } frpa_state_t;

endpackage : frpa_pkg

// ==== frpa_bus_cycle.sv ====
/*
 * One asynchronous bus cycle (read or write) on the flash pins.
 * Assumes start is a one-cycle pulse given only while done is not pending
 * and the engine is idle; data input arrives from a pin.
 */
`timescale 1ns/1ps
`include "frpa_map.svh"

module frpa_bus_cycle (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic is_write,
    input wire logic [19:0] addr,
    input wire logic [7:0] wdata,
    output logic done_r,
    output logic [7:0] rdata_r,
    output logic idle_r,
    output logic ce_n_r,
    output logic oe_n_r,
    output logic we_n_r,
    output logic [19:0] addr_r,
    output logic [7:0] dq_out_r,
    output logic dq_oe_r,
    input wire logic [7:0] dq_in
);

    localparam logic [7:0] WE_CYC = 8'(`FRPA_CYC_MIN(`FRPA_WE_PULSE_NS));
    // Two extra cycles cover the input synchroniser
    localparam logic [7:0] RD_CYC = 8'(`FRPA_CYC_MIN(`FRPA_ACCESS_NS) + 2);

    typedef enum logic [2:0] {FRPA_B_IDLE, FRPA_B_SETUP, FRPA_B_STROBE, FRPA_B_HOLD, FRPA_B_READ} frpa_bstate_t;

    frpa_bstate_t st_r;
    logic [7:0] cnt_r;
    logic [7:0] dq_meta_r;
    logic [7:0] dq_sync_r;

    // Data pins are asynchronous to clk
    always_ff @(posedge clk) begin
        dq_meta_r <= dq_in;
        dq_sync_r <= dq_meta_r;
    end

    // Pin sequencing; write strobe is never low unless output gate is high
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= FRPA_B_IDLE;
            cnt_r <= 8'h00;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            idle_r <= 1'b1;
            ce_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            addr_r <= 20'h00000;
            dq_out_r <= 8'h00;
            dq_oe_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (st_r)
                FRPA_B_IDLE: begin
                    if (start) begin
                        idle_r <= 1'b0;
                        addr_r <= addr;
                        ce_n_r <= 1'b0;
                        cnt_r <= 8'h00;
                        if (is_write) begin
                            oe_n_r <= 1'b1;
                            dq_out_r <= wdata;
                            dq_oe_r <= 1'b1;
                            st_r <= FRPA_B_SETUP;
                        end else begin
                            oe_n_r <= 1'b0;
                            st_r <= FRPA_B_READ;
                        end
                    end
                end
                FRPA_B_SETUP: begin
                    // Strobe only after chip select and gate have settled
                    we_n_r <= 1'b0;
                    st_r <= FRPA_B_STROBE;
                end
                FRPA_B_STROBE: begin
                    // Pulse kept well above the noise width the device rejects
                    if (cnt_r == WE_CYC - 8'h01) begin
                        we_n_r <= 1'b1;
                        st_r <= FRPA_B_HOLD;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                FRPA_B_HOLD: begin
                    ce_n_r <= 1'b1;
                    dq_oe_r <= 1'b0;
                    done_r <= 1'b1;
                    idle_r <= 1'b1;
                    st_r <= FRPA_B_IDLE;
                end
                FRPA_B_READ: begin
                    if (cnt_r == RD_CYC - 8'h01) begin
                        rdata_r <= dq_sync_r;
                        ce_n_r <= 1'b1;
                        oe_n_r <= 1'b1;
                        done_r <= 1'b1;
                        idle_r <= 1'b1;
                        st_r <= FRPA_B_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 8'h01;
                    end
                end
                default: st_r <= FRPA_B_IDLE;
            endcase
        end
    end

endmodule : frpa_bus_cycle

// ==== frpa_host.sv ====
/*
 * Host controller for a byte-wide parallel flash: reads, unlocked program
 * and sector erase, identifier reads by command or by high voltage, hard
 * reset pulses and temporary group unprotect.
 * Assumes the board converts hv_a9_en and hv_reset_en into the high
 * voltage level on the address pin A9 and on the reset pin.
 */
`timescale 1ns/1ps
`include "frpa_map.svh"

// Summary of operation
// - Idle reset completes in recovery time; read only after release delay.
// - Host flags, in interrupted_r, an operation that a hard reset interrupted.
// - Host holds control pins inactive so no stray write occurs.
// - Write only with chip select and strobe low, gate high.
module frpa_host #(
    parameter logic [19:0] UNLOCK_ADDR_A = 20'h00001,
    parameter logic [19:0] UNLOCK_ADDR_B = 20'h00002,
    parameter logic [7:0] UNLOCK_CODE_A = 8'h11,
    parameter logic [7:0] UNLOCK_CODE_B = 8'h22,
    parameter logic [7:0] CMD_PROGRAM = 8'h33,
    parameter logic [7:0] CMD_ERASE_SETUP = 8'h44,
    parameter logic [7:0] CMD_SECTOR_ERASE = 8'h55,
    parameter logic [7:0] CMD_AUTOSELECT = 8'h66,
    parameter logic [7:0] CMD_RESET = 8'h77,
    parameter int READY_ALG_NS = `FRPA_READY_ALG_NS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire frpa_pkg::frpa_op_t op,
    input wire logic [19:0] addr,
    input wire logic [7:0] wdata,
    input wire logic temp_unprotect,
    output logic ready_r,
    output logic done_r,
    output logic [7:0] rdata_r,
    output logic protected_r,
    output logic interrupted_r,
    output logic timeout_r,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [19:0] addr_pin,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic [7:0] data_lines_in,
    output logic reset_pin_n_r,
    output logic hv_reset_en_r,
    output logic hv_a9_en_r,
    input wire logic ready_busy_n
);

    localparam logic [15:0] CLR_CYC = 16'(`FRPA_CYC_MIN(`FRPA_CLEAR_PULSE_MIN_NS));
    localparam logic [15:0] IDLE_RCV_CYC = 16'(`FRPA_CYC_MIN(`FRPA_READY_IDLE_NS));
    localparam logic [15:0] ALG_RCV_CYC = 16'(`FRPA_CYC_MIN(READY_ALG_NS));
    localparam logic [15:0] RH_CYC = 16'(`FRPA_CYC_MIN(`FRPA_READ_AFTER_RELEASE_NS));
    localparam logic [15:0] SETTLE_CYC = 16'(`FRPA_CYC_MIN(`FRPA_BUSY_SETTLE_NS));

    frpa_pkg::frpa_state_t st_r;
    frpa_pkg::frpa_op_t op_r;
    logic [19:0] addr_r;
    logic [7:0] wdata_r;
    logic [2:0] step_r;
    logic [15:0] cnt_r;
    logic rb_meta_r;
    logic rb_sync_r;
    logic was_busy_r;
    logic cyc_start_r;
    logic cyc_done;
    logic cyc_idle;
    logic [7:0] cyc_rdata;
    logic [19:0] seq_addr;
    logic [7:0] seq_data;
    logic seq_write;

    // Last step index of each operation
    function automatic logic [2:0] last_step(input frpa_pkg::frpa_op_t o);
        unique case (o)
            frpa_pkg::FRPA_OP_PROGRAM: last_step = 3'h3;
            frpa_pkg::FRPA_OP_ERASE_SECTOR: last_step = 3'h5;
            frpa_pkg::FRPA_OP_ID_CMD: last_step = 3'h4;
            default: last_step = 3'h0;
        endcase
    endfunction : last_step

    // Identifier address: A9 and A6 at logic low, A1..A0 and group kept
    function automatic logic [19:0] id_addr(input logic [19:0] a);
        logic [19:0] r;
        r = a;
        r[`FRPA_A9_BIT] = 1'b0;
        r[`FRPA_A6_BIT] = 1'b0;
        id_addr = r;
    endfunction : id_addr

    // Bus cycle for the current step of the current operation
    always_comb begin
        seq_addr = addr_r;
        seq_data = wdata_r;
        seq_write = 1'b0;
        if (last_step(op_r) != 3'h0) begin
            seq_write = 1'b1;
            // Unlock pairs precede every command byte but the reset that closes an identifier read
            unique case (step_r)
                3'h0, 3'h3: begin
                    seq_addr = UNLOCK_ADDR_A;
                    seq_data = UNLOCK_CODE_A;
                end
                3'h1, 3'h4: begin
                    seq_addr = UNLOCK_ADDR_B;
                    seq_data = UNLOCK_CODE_B;
                end
                3'h2: begin
                    seq_addr = UNLOCK_ADDR_A;
                    seq_data = (op_r == frpa_pkg::FRPA_OP_PROGRAM) ? CMD_PROGRAM :
                               (op_r == frpa_pkg::FRPA_OP_ERASE_SECTOR) ? CMD_ERASE_SETUP : CMD_AUTOSELECT;
                end
                default: ;
            endcase
            if (op_r == frpa_pkg::FRPA_OP_PROGRAM && step_r == 3'h3) begin
                seq_addr = addr_r;
                seq_data = wdata_r;
            end
            if (op_r == frpa_pkg::FRPA_OP_ERASE_SECTOR && step_r == 3'h5) begin
                // Sector chosen by A19..A16 only
                seq_addr = {addr_r[19:`FRPA_SECTOR_LSB], 16'h0000};
                seq_data = CMD_SECTOR_ERASE;
            end
            if (op_r == frpa_pkg::FRPA_OP_ID_CMD && step_r == 3'h3) begin
                seq_write = 1'b0;
                seq_addr = id_addr(addr_r);
            end
            if (op_r == frpa_pkg::FRPA_OP_ID_CMD && step_r == 3'h4) begin
                // Leave identifier mode so array reads work again
                seq_addr = addr_r;
                seq_data = CMD_RESET;
            end
        end else if (op_r == frpa_pkg::FRPA_OP_ID_HV) begin
            seq_addr = id_addr(addr_r);
        end
    end

    // Ready/busy pin is asynchronous
    always_ff @(posedge clk) begin
        rb_meta_r <= ready_busy_n;
        rb_sync_r <= rb_meta_r;
    end

    // Main sequencer
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r <= frpa_pkg::FRPA_S_IDLE;
            op_r <= frpa_pkg::FRPA_OP_READ;
            addr_r <= 20'h00000;
            wdata_r <= 8'h00;
            step_r <= 3'h0;
            cnt_r <= 16'h0000;
            was_busy_r <= 1'b0;
            cyc_start_r <= 1'b0;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            protected_r <= 1'b0;
            interrupted_r <= 1'b0;
            timeout_r <= 1'b0;
            reset_pin_n_r <= 1'b1;
            hv_a9_en_r <= 1'b0;
        end else begin
            cyc_start_r <= 1'b0;
            done_r <= 1'b0;
            unique case (st_r)
                frpa_pkg::FRPA_S_IDLE: begin
                    ready_r <= cyc_idle;
                    if (req && ready_r) begin
                        ready_r <= 1'b0;
                        op_r <= op;
                        addr_r <= addr;
                        wdata_r <= wdata;
                        step_r <= 3'h0;
                        cnt_r <= 16'h0000;
                        timeout_r <= 1'b0;
                        if (op == frpa_pkg::FRPA_OP_HW_RESET) begin
                            // Remember whether an algorithm was running
                            was_busy_r <= !rb_sync_r;
                            reset_pin_n_r <= 1'b0;
                            st_r <= frpa_pkg::FRPA_S_RST_LOW;
                        end else begin
                            interrupted_r <= 1'b0;
                            hv_a9_en_r <= (op == frpa_pkg::FRPA_OP_ID_HV);
                            st_r <= frpa_pkg::FRPA_S_ISSUE;
                        end
                    end
                end
                frpa_pkg::FRPA_S_ISSUE: begin
                    cyc_start_r <= 1'b1;
                    st_r <= frpa_pkg::FRPA_S_CYCLE;
                end
                frpa_pkg::FRPA_S_CYCLE: begin
                    if (cyc_done) begin
                        if (!seq_write) begin
                            rdata_r <= cyc_rdata;
                            protected_r <= cyc_rdata[0];
                        end
                        if (step_r == last_step(op_r)) begin
                            hv_a9_en_r <= 1'b0;
                            cnt_r <= 16'h0000;
                            if (op_r == frpa_pkg::FRPA_OP_PROGRAM || op_r == frpa_pkg::FRPA_OP_ERASE_SECTOR) begin
                                st_r <= frpa_pkg::FRPA_S_SETTLE;
                            end else begin
                                done_r <= 1'b1;
                                st_r <= frpa_pkg::FRPA_S_IDLE;
                            end
                        end else begin
                            step_r <= step_r + 3'h1;
                            st_r <= frpa_pkg::FRPA_S_ISSUE;
                        end
                    end
                end
                frpa_pkg::FRPA_S_SETTLE: begin
                    // Give the busy output time to fall before watching it
                    if (cnt_r == SETTLE_CYC - 16'h0001) begin
                        cnt_r <= 16'h0000;
                        st_r <= frpa_pkg::FRPA_S_BUSY;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                frpa_pkg::FRPA_S_BUSY: begin
                    // A refused protected-group write never drops busy
                    if (rb_sync_r) begin
                        done_r <= 1'b1;
                        st_r <= frpa_pkg::FRPA_S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                frpa_pkg::FRPA_S_RST_LOW: begin
                    // Pulse never shorter than the clear minimum
                    if (cnt_r == CLR_CYC - 16'h0001) begin
                        reset_pin_n_r <= 1'b1;
                        cnt_r <= 16'h0000;
                        st_r <= frpa_pkg::FRPA_S_RST_RECOVER;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                frpa_pkg::FRPA_S_RST_RECOVER: begin
                    // Busy recovery ends on the ready pin or at the timeout, idle one on time
                    if (was_busy_r ? rb_sync_r : (cnt_r == IDLE_RCV_CYC - 16'h0001)) begin
                        cnt_r <= 16'h0000;
                        st_r <= frpa_pkg::FRPA_S_RST_HOLDOFF;
                    end else if (was_busy_r && cnt_r == ALG_RCV_CYC - 16'h0001) begin
                        timeout_r <= 1'b1;
                        cnt_r <= 16'h0000;
                        st_r <= frpa_pkg::FRPA_S_RST_HOLDOFF;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                frpa_pkg::FRPA_S_RST_HOLDOFF: begin
                    // No read before the release delay has passed
                    if (cnt_r == RH_CYC - 16'h0001) begin
                        interrupted_r <= was_busy_r;
                        done_r <= 1'b1;
                        st_r <= frpa_pkg::FRPA_S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: st_r <= frpa_pkg::FRPA_S_IDLE;
            endcase
        end
    end

    // Temporary unprotect follows the user level only between operations
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hv_reset_en_r <= 1'b0;
        end else if (st_r == frpa_pkg::FRPA_S_IDLE) begin
            // Dropped on the edge that pulls the pin low, so the two never overlap
            hv_reset_en_r <= temp_unprotect && !(req && ready_r && op == frpa_pkg::FRPA_OP_HW_RESET);
        end else if (st_r == frpa_pkg::FRPA_S_RST_LOW) begin
            hv_reset_en_r <= 1'b0;
        end
    end

    // Pin engine; controls idle inactive with all strobes high
    frpa_bus_cycle u_cycle (
        .clk(clk),
        .rstn(rstn),
        .start(cyc_start_r),
        .is_write(seq_write),
        .addr(seq_addr),
        .wdata(seq_data),
        .done_r(cyc_done),
        .rdata_r(cyc_rdata),
        .idle_r(cyc_idle),
        .ce_n_r(ce_n),
        .oe_n_r(oe_n),
        .we_n_r(we_n),
        .addr_r(addr_pin),
        .dq_out_r(data_lines_out),
        .dq_oe_r(data_lines_oe),
        .dq_in(data_lines_in)
    );

endmodule : frpa_host

// ==== frpa_host_props.sv ====
/* Pin assertions for the flash host controller.
   Sees only the ports of frpa_host; bound in below. */
`timescale 1ns/1ps
module frpa_host_props (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire logic ready_r,
    input wire logic done_r,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic data_lines_oe,
    input wire logic reset_pin_n_r,
    input wire logic hv_reset_en_r,
    input wire logic hv_a9_en_r
);
    logic [7:0] low_cnt_r;
    // Reset pin low time; saturates so a stuck pin cannot wrap back to a legal count
    always_ff @(posedge clk) begin
        if (!rstn || reset_pin_n_r) begin
            low_cnt_r <= 8'h00;
        end else if (low_cnt_r != 8'hff) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_quiet;
        ce_n && oe_n && we_n;
    endsequence
    sequence s_holdoff;
        (ce_n && oe_n)[*5];
    endsequence
    a_write_gate_ok: assert property (!we_n |-> !ce_n && oe_n)
        else $error("write strobe outside a write");
    a_idle_pins_quiet: assert property (ready_r |-> s_quiet)
        else $error("control pins active while idle");
    a_reset_pulse_len: assert property ($rose(reset_pin_n_r) |-> low_cnt_r == 8'h32)
        else $error("reset pulse not fifty cycles");
    a_reset_no_access: assert property (!reset_pin_n_r |-> s_quiet)
        else $error("bus access during reset pulse");
    a_release_holdoff: assert property ($rose(reset_pin_n_r) |-> s_holdoff)
        else $error("access too soon after release");
    a_unprotect_off: assert property (!reset_pin_n_r |-> !hv_reset_en_r)
        else $error("high voltage during reset pulse");
    a_id_hv_read: assert property (hv_a9_en_r |-> we_n)
        else $error("write during A9 high voltage");
    a_gate_no_fight: assert property (!oe_n |-> !data_lines_oe && we_n)
        else $error("data driven while gate low");
    a_done_then_ready: assert property (done_r |=> ready_r && !done_r)
        else $error("done not one cycle or ready late");
    a_req_taken: assert property (req && ready_r |=> !ready_r)
        else $error("request not taken");
endmodule : frpa_host_props

bind frpa_host frpa_host_props u_props (.clk, .rstn, .req, .ready_r, .done_r, .ce_n, .oe_n, .we_n,
    .data_lines_oe, .reset_pin_n_r, .hv_reset_en_r, .hv_a9_en_r);

// ==== frpa_flash_model.sv ====
/* Behavioural flash: array, protection groups, unlock decoder, identifiers.
   Assumes registered host pins, the bench clock and the host's default codes. */
`timescale 1ns/1ps
module frpa_flash_model #(
    parameter logic [7:0] PROT_MASK = 8'h04,
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [7:0] DEVICE_CODE = 8'hc3,
    parameter int BUSY_CYC = 30
) (
    input wire logic clk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [19:0] addr_pin,
    input wire logic [7:0] data_lines_out,
    input wire logic data_lines_oe,
    input wire logic reset_pin_n,
    input wire logic hv_reset_en,
    input wire logic hv_a9_en,
    output logic [7:0] data_lines_in,
    output logic ready_busy_n
);
    logic [7:0] mem [logic [19:0]];
    logic [2:0] step_r = 3'h0; // Array read at power-up, decoder cleared
    logic id_r = 1'b0;
    logic we_prev_r = 1'b1; // A strobe already low at power-up is taken only if it rises after the first edge
    logic [7:0] last_r = 8'h00;
    int busy_r = 0;
    logic [7:0] rd_val;
    logic prot;
    assign prot = PROT_MASK[addr_pin[19:17]] && !hv_reset_en;
    assign ready_busy_n = (busy_r == 0);
    // Released lines show the inverse of the last level, never a stale value
    assign data_lines_in = data_lines_oe ? data_lines_out
        : (!ce_n && !oe_n && reset_pin_n) ? rd_val : ~last_r;
    // Read source: identifier codes or the array byte (erased reads ff)
    always_comb begin
        if ((hv_a9_en && !addr_pin[6]) || id_r) begin
            case (addr_pin[1:0])
                2'h0: rd_val = MAKER_CODE;
                2'h1: rd_val = DEVICE_CODE;
                default: rd_val = {7'h00, PROT_MASK[addr_pin[19:17]]};
            endcase
        end else begin
            rd_val = mem.exists(addr_pin) ? mem[addr_pin] : 8'hff;
        end
    end
    // Command decoder; any wrong cycle drops back to the first unlock
    task automatic take(input logic [19:0] a, input logic [7:0] d);
        logic [19:0] q [$];
        step_r <= 3'h0;
        if (d == 8'h77) id_r <= 1'b0;
        case (step_r)
            3'h0, 3'h4: if (a == 20'h00001 && d == 8'h11) step_r <= step_r + 3'h1;
            3'h1, 3'h5: if (a == 20'h00002 && d == 8'h22) step_r <= step_r + 3'h1;
            3'h2: begin
                if (d == 8'h66) id_r <= 1'b1;
                if (d == 8'h33) step_r <= 3'h3;
                if (d == 8'h44) step_r <= 3'h4;
            end
            3'h3: if (!prot) begin
                mem[a] = d;
                busy_r <= BUSY_CYC;
            end
            3'h6: if (d == 8'h55 && !prot) begin
                foreach (mem[k]) if (k[19:16] == a[19:16]) q.push_back(k);
                foreach (q[i]) mem.delete(q[i]);
                busy_r <= BUSY_CYC;
            end
            default: step_r <= 3'h0;
        endcase
    endtask : take
    // Write taken on strobe rise with select low, gate high; sub-cycle glitches unseen
    always @(posedge clk) begin
        last_r <= data_lines_in;
        we_prev_r <= we_n;
        if (busy_r > 0) busy_r <= busy_r - 1; // Reset does not shorten recovery
        if (!reset_pin_n) begin
            step_r <= 3'h0;
            id_r <= 1'b0;
        end else if (!we_prev_r && we_n && !ce_n && oe_n && busy_r == 0) begin
            take(addr_pin, data_lines_out);
        end
    end
endmodule : frpa_flash_model

// ==== test_flash_reset_protect_autoselect.sv ====
/* Self-checking bench for frpa_host against the behavioural flash model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
module test_flash_reset_protect_autoselect;
    localparam logic [7:0] MAKER = 8'h5a; // Arbitrary identifier value
    localparam logic [7:0] DEVICE = 8'hc3; // Arbitrary identifier value
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req = 1'b0;
    frpa_pkg::frpa_op_t op = frpa_pkg::FRPA_OP_READ;
    logic [19:0] addr = 20'h00000;
    logic [7:0] wdata = 8'h00;
    logic temp_unprotect = 1'b0;
    logic ready_r, done_r, protected_r, interrupted_r, timeout_r, ce_n, oe_n, we_n;
    logic data_lines_oe, reset_pin_n_r, hv_reset_en_r, hv_a9_en_r, ready_busy_n;
    logic [7:0] rdata_r, data_lines_out, data_lines_in;
    logic [19:0] addr_pin;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    frpa_host #(.READY_ALG_NS(500)) uut (.clk, .rstn, .req, .op, .addr, .wdata, .temp_unprotect, .ready_r,
        .done_r, .rdata_r, .protected_r, .interrupted_r, .timeout_r, .ce_n, .oe_n, .we_n, .addr_pin,
        .data_lines_out, .data_lines_oe, .data_lines_in, .reset_pin_n_r, .hv_reset_en_r, .hv_a9_en_r,
        .ready_busy_n);
    frpa_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash (.clk, .ce_n, .oe_n, .we_n, .addr_pin,
        .data_lines_out, .data_lines_oe, .reset_pin_n(reset_pin_n_r), .hv_reset_en(hv_reset_en_r),
        .hv_a9_en(hv_a9_en_r), .data_lines_in, .ready_busy_n);
    // 100 MHz clock
    always #5 clk = ~clk;
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // Hang guard: the whole sequence needs about a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One user operation: wait idle, pulse req, wait for done under a bound
    task automatic run_op(input frpa_pkg::frpa_op_t o, input logic [19:0] a, input logic [7:0] d);
        int n = 0;
        while (ready_r !== 1'b1 && n < 3000) begin
            @(posedge clk); #1;
            n++;
        end
        op = o;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(posedge clk); #1;
        req = 1'b0;
        n = 0;
        while (done_r !== 1'b1 && n < 3000) begin
            @(posedge clk); #1;
            n++;
        end
        chk("done", 8'h01, {7'h00, done_r});
    endtask : run_op
    task automatic rd_chk(input string name, input logic [19:0] a, input logic [7:0] exp);
        run_op(frpa_pkg::FRPA_OP_READ, a, 8'h00);
        chk(name, exp, rdata_r);
    endtask : rd_chk
    task automatic t_program();
        rd_chk("blank", 20'h12345, 8'hff);
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h12345, 8'h3c);
        rd_chk("programmed", 20'h12345, 8'h3c);
    endtask : t_program
    task automatic t_protect();
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h50010, 8'h5a);
        rd_chk("protected", 20'h50010, 8'hff);
        temp_unprotect = 1'b1;
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h40020, 8'h96);
        rd_chk("unprotected", 20'h40020, 8'h96);
        temp_unprotect = 1'b0;
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h40030, 8'h69);
        rd_chk("reprotected", 20'h40030, 8'hff);
    endtask : t_protect
    task automatic t_erase();
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h30004, 8'h12);
        run_op(frpa_pkg::FRPA_OP_PROGRAM, 20'h20004, 8'h34);
        run_op(frpa_pkg::FRPA_OP_ERASE_SECTOR, 20'h3ffff, 8'h00);
        rd_chk("erased", 20'h30004, 8'hff);
        rd_chk("neighbour", 20'h20004, 8'h34);
    endtask : t_erase
    // Both identifier methods, all three selectors, free and locked group
    task automatic t_ident();
        logic [7:0] exp;
        logic [19:0] a;
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                a = {(i == 3) ? 3'h2 : 3'h0, 15'h0000, (i > 1) ? 2'h2 : 2'(i)};
                exp = (i == 0) ? MAKER : (i == 1) ? DEVICE : (i == 3) ? 8'h01 : 8'h00;
                run_op(m ? frpa_pkg::FRPA_OP_ID_HV : frpa_pkg::FRPA_OP_ID_CMD, a, 8'h00);
                chk("ident", exp, rdata_r);
                if (i > 1) chk("prot_flag", exp, {7'h00, protected_r});
            end
        end
        rd_chk("array_back", 20'h12345, 8'h3c);
    endtask : t_ident
    task automatic t_hw_reset();
        run_op(frpa_pkg::FRPA_OP_HW_RESET, 20'h00000, 8'h00);
        chk("interrupted", 8'h00, {7'h00, interrupted_r});
        chk("timeout", 8'h00, {7'h00, timeout_r});
        rd_chk("after_reset", 20'h12345, 8'h3c);
    endtask : t_hw_reset
    // Reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_program();
        t_protect();
        t_erase();
        t_ident();
        t_hw_reset();
        complete_run();
    end
endmodule : test_flash_reset_protect_autoselect
